// File: rgc_host_model.sv
// serial bus master model standing in for the host processor
`default_nettype none

module rgc_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drive_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_drive_n = 1'b1;
  end

  // set both lines, then let n falling edges pass
  task automatic step(input logic c, input logic d, input int n);
    scl = c;
    sda_drive_n = d;
    repeat (n) @(negedge clk);
  endtask

  // start (1,0) or stop (0,1); first level set with the clock low, last level with the clock high
  task automatic cond(input logic first, input logic last);
    step(1'b0, sda_drive_n, 3);
    step(1'b0, first, 3);
    step(1'b1, first, 4);
    step(1'b1, last, 4);
  endtask

  // one bit out and in, sampled mid high phase
  task automatic bit_io(input logic d, output logic q);
    step(1'b0, sda_drive_n, 3);
    step(1'b0, d, 4);
    step(1'b1, d, 3);
    q = sda;
    step(1'b1, d, 3);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask

  // nack is 1 when any byte went unanswered
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic nack);
    logic [7:0] q;
    logic       a0, a1, a2;
    cond(1'b1, 1'b0);
    byte_io({dev, 1'b0}, 1'b1, q, a0);
    byte_io(ptr, 1'b1, q, a1);
    byte_io(data, 1'b1, q, a2);
    cond(1'b0, 1'b1);
    nack = a0 | a1 | a2;
  endtask

  // single byte read, ended by a master nack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
    logic [7:0] q;
    logic       a;
    cond(1'b1, 1'b0);
    byte_io({rgc_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, a);
    byte_io(ptr, 1'b1, q, a);
    cond(1'b1, 1'b0);
    byte_io({rgc_pkg::DEVICE_ADDR, 1'b1}, 1'b1, q, a);
    byte_io(8'hFF, 1'b1, data, a);
    cond(1'b0, 1'b1);
  endtask
endmodule

`default_nettype wire

// File: rgc_pkg.sv
// constants and register layout for the regulator control register bank
`default_nettype none

package rgc_pkg;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SOFTSTART_TIME_NS = 80000;
  localparam int SOFTSTART_CYCLES  = (SOFTSTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // -------------------------------------------------------------------------
  // serial interface
  // -------------------------------------------------------------------------
  localparam logic [6:0] DEVICE_ADDR = 7'h5_A; // arbitrary bus address

  // -------------------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0] LDO7_VOLTAGE_RANGE_ADDR = 8'h07;
  localparam logic [7:0] BUCK_VSEL_ADDR          = 8'h14;
  localparam logic [7:0] BUCK_MODE_ADDR          = 8'h15;
  localparam logic [7:0] BUCK_RESERVED_ADDR      = 8'h16;
  localparam logic [7:0] BUCK_CONTROL_ADDR       = 8'h17;
  localparam int         NUM_LDO                 = 8;
  // control register of regulators 1..8, index 0 is regulator 1
  localparam logic [7:0] LDO_CONTROL_ADDR [NUM_LDO] =
    '{8'h0F, 8'h13, 8'h0C, 8'h10, 8'h0D, 8'h11, 8'h0E, 8'h12};
  localparam int         LDO7_INDEX              = 6;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int LDO_VSEL_MSB      = 4;
  localparam int LDO_ENABLE_BIT    = 5;
  localparam int LDO_GOOD_BIT      = 6;
  localparam int LDO_DISCHARGE_BIT = 7;
  localparam int WIDE_VSEL_MSB     = 5;
  localparam int RANGE_BIT         = 6;
  localparam int BUCK_MODE_BIT     = 0;
  localparam int BUCK_ENABLE_BIT   = 0;
  localparam int BUCK_GOOD_BIT     = 1;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [5:0] BUCK_VSEL_RESET      = 6'h2_0;
  localparam logic       BUCK_RANGE_RESET     = 1'b1;
  localparam logic       BUCK_MODE_RESET      = 1'b0;
  localparam logic       BUCK_ENABLE_RESET    = 1'b1;
  localparam logic [5:0] LDO_VSEL_RESET       = 6'h0_0;
  localparam logic       LDO7_RANGE_RESET     = 1'b0;
  localparam logic       LDO_ENABLE_RESET     = 1'b0;
  localparam logic       LDO_DISCHARGE_RESET  = 1'b0;

endpackage

`default_nettype wire

// File: rgc_reg_if.sv
// register access carrier between the serial slave and the register bank
`default_nettype none

interface rgc_reg_if;
  logic       write;  // one-cycle write strobe
  logic [7:0] addr;   // register pointer
  logic [7:0] wdata;
  logic [7:0] rdata;  // combinational read data at addr

  modport master (output write, output addr, output wdata, input rdata);
  modport bank   (input write, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// File: rgc_regulator_control.sv
// regulator control register bank with converter enable and soft-start logic
`default_nettype none

module rgc_regulator_control #(
  parameter int SOFTSTART_CYCLES = rgc_pkg::SOFTSTART_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_drive_n,
  input  wire logic        handsfree_power_request,
  input  wire logic        power_on_request,
  input  wire logic        power_hold_request,
  input  wire logic        buck_output_good,
  input  wire logic [7:0]  ldo_output_good,
  output logic             buck_enable,
  output logic             buck_forced_pwm,
  output logic [5:0]       buck_voltage_select,
  output logic             buck_range_select,
  output logic             buck_soft_start,
  output logic [7:0]       ldo_enable,
  output logic [7:0]       ldo_discharge,
  output logic [7:0][5:0]  ldo_voltage_select,
  output logic             ldo7_range_select
);

  // -------------------------------------------------------------------------
  // serial access
  // -------------------------------------------------------------------------
  rgc_reg_if regs ();

  rgc_serial_slave rgc_serial_slave_inst (
    .clk         (clk),
    .rst         (rst),
    .scl         (scl),
    .sda_in      (sda_in),
    .sda_drive_n (sda_drive_n),
    .regs        (regs)
  );

  // open-drain data pin only ever pulls low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // converter registers
  // -------------------------------------------------------------------------
  logic buck_enable_bit;

  // voltage select, range, mode and enable bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck_voltage_select <= rgc_pkg::BUCK_VSEL_RESET;
      buck_range_select   <= rgc_pkg::BUCK_RANGE_RESET;
      buck_forced_pwm     <= rgc_pkg::BUCK_MODE_RESET;
      buck_enable_bit     <= rgc_pkg::BUCK_ENABLE_RESET;
    end else if (regs.write) begin
      if (regs.addr == rgc_pkg::BUCK_VSEL_ADDR) begin
        buck_voltage_select <= regs.wdata[rgc_pkg::WIDE_VSEL_MSB:0];
        buck_range_select   <= regs.wdata[rgc_pkg::RANGE_BIT];
      end
      if (regs.addr == rgc_pkg::BUCK_MODE_ADDR) begin
        buck_forced_pwm <= regs.wdata[rgc_pkg::BUCK_MODE_BIT];
      end
      // power-good bit in the same register is read-only
      if (regs.addr == rgc_pkg::BUCK_CONTROL_ADDR) begin
        buck_enable_bit <= regs.wdata[rgc_pkg::BUCK_ENABLE_BIT];
      end
    end
  end

  // -------------------------------------------------------------------------
  // converter enable
  // -------------------------------------------------------------------------
  logic any_request;
  assign any_request = handsfree_power_request | power_on_request | power_hold_request;

  // the enable bit can only veto, it never turns the converter on alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck_enable <= 1'b0;
    end else begin
      buck_enable <= any_request & buck_enable_bit;
    end
  end

  // -------------------------------------------------------------------------
  // soft-start timer
  // -------------------------------------------------------------------------
  logic [31:0] ramp_count;
  logic        ramp_done;
  assign ramp_done = (ramp_count >= 32'(SOFTSTART_CYCLES));

  // restarts from zero each time the converter is turned on again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_count <= 32'h0000_0000;
    end else if (!buck_enable) begin
      ramp_count <= 32'h0000_0000;
    end else if (!ramp_done) begin
      ramp_count <= ramp_count + 32'h0000_0001;
    end
  end

  // ramp flag high for exactly the soft-start window after enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buck_soft_start <= 1'b0;
    end else begin
      buck_soft_start <= buck_enable & ~ramp_done & any_request & buck_enable_bit;
    end
  end

  // -------------------------------------------------------------------------
  // linear regulator registers
  // -------------------------------------------------------------------------
  logic [7:0] ldo_enable_bit;
  logic [7:0] ldo_discharge_bit;

  // one control register per regulator, same layout except that regulator 7 has no select field in it
  for (genvar i = 0; i < rgc_pkg::NUM_LDO; i++) begin : g_ldo
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ldo_enable_bit[i]    <= rgc_pkg::LDO_ENABLE_RESET;
        ldo_discharge_bit[i] <= rgc_pkg::LDO_DISCHARGE_RESET;
      end else if (regs.write && regs.addr == rgc_pkg::LDO_CONTROL_ADDR[i]) begin
        ldo_enable_bit[i]    <= regs.wdata[rgc_pkg::LDO_ENABLE_BIT];
        ldo_discharge_bit[i] <= regs.wdata[rgc_pkg::LDO_DISCHARGE_BIT];
      end
    end

    // voltage select: regulator 7 keeps its wider field in its own register
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ldo_voltage_select[i] <= rgc_pkg::LDO_VSEL_RESET;
      end else if (i == rgc_pkg::LDO7_INDEX) begin
        if (regs.write && regs.addr == rgc_pkg::LDO7_VOLTAGE_RANGE_ADDR) begin
          ldo_voltage_select[i] <= regs.wdata[rgc_pkg::WIDE_VSEL_MSB:0];
        end
      end else if (regs.write && regs.addr == rgc_pkg::LDO_CONTROL_ADDR[i]) begin
        ldo_voltage_select[i] <= {1'b0, regs.wdata[rgc_pkg::LDO_VSEL_MSB:0]};
      end
    end

    // outputs drive the regulator: discharge only acts while it is off
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ldo_enable[i]    <= 1'b0;
        ldo_discharge[i] <= 1'b0;
      end else begin
        ldo_enable[i]    <= ldo_enable_bit[i];
        ldo_discharge[i] <= ldo_discharge_bit[i] & ~ldo_enable_bit[i];
      end
    end
  end

  // regulator 7 range bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ldo7_range_select <= rgc_pkg::LDO7_RANGE_RESET;
    end else if (regs.write && regs.addr == rgc_pkg::LDO7_VOLTAGE_RANGE_ADDR) begin
      ldo7_range_select <= regs.wdata[rgc_pkg::RANGE_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  // power-good bits come straight from the comparators, so a read sees
  // the level of that very cycle; unmapped addresses read as zero
  always_comb begin
    logic [7:0] value;
    value = 8'h00;
    unique case (regs.addr)
      rgc_pkg::LDO7_VOLTAGE_RANGE_ADDR: begin
        value[rgc_pkg::WIDE_VSEL_MSB:0] = ldo_voltage_select[rgc_pkg::LDO7_INDEX];
        value[rgc_pkg::RANGE_BIT]       = ldo7_range_select;
      end
      rgc_pkg::BUCK_VSEL_ADDR: begin
        value[rgc_pkg::WIDE_VSEL_MSB:0] = buck_voltage_select;
        value[rgc_pkg::RANGE_BIT]       = buck_range_select;
      end
      rgc_pkg::BUCK_MODE_ADDR: begin
        value[rgc_pkg::BUCK_MODE_BIT] = buck_forced_pwm;
      end
      rgc_pkg::BUCK_CONTROL_ADDR: begin
        value[rgc_pkg::BUCK_ENABLE_BIT] = buck_enable_bit;
        value[rgc_pkg::BUCK_GOOD_BIT]   = buck_output_good;
      end
      default: begin
        for (int i = 0; i < rgc_pkg::NUM_LDO; i++) begin
          if (regs.addr == rgc_pkg::LDO_CONTROL_ADDR[i]) begin
            if (i != rgc_pkg::LDO7_INDEX) begin
              value[rgc_pkg::LDO_VSEL_MSB:0] =
                ldo_voltage_select[i][rgc_pkg::LDO_VSEL_MSB:0];
            end
            value[rgc_pkg::LDO_ENABLE_BIT]    = ldo_enable_bit[i];
            value[rgc_pkg::LDO_GOOD_BIT]      = ldo_output_good[i];
            value[rgc_pkg::LDO_DISCHARGE_BIT] = ldo_discharge_bit[i];
          end
        end
      end
    endcase
    regs.rdata = value;
  end

endmodule

`default_nettype wire

// File: rgc_regulator_control_bench.sv
// self-checking testbench for the regulator control register bank
`default_nettype none

module rgc_regulator_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SS = 50;

  logic            clk, rst, scl, sda, host_n, drv_n, sda_out, buck_good;
  logic [2:0]      req;
  logic [7:0]      ldo_good, ldo_en, ldo_dis, rd;
  logic            buck_en, pwm, brange, ss, l7range, nack;
  logic [5:0]      bvsel;
  logic [7:0][5:0] lvsel;
  logic [7:0]      a, e;
  int              failures, comparisons, cycles;

  // open-drain line with pull-up
  assign sda = host_n & drv_n;

  rgc_regulator_control #(.SOFTSTART_CYCLES(SS)) rgc_regulator_control_inst (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_drive_n(drv_n), .handsfree_power_request(req[0]), .power_on_request(req[1]),
    .power_hold_request(req[2]), .buck_output_good(buck_good), .ldo_output_good(ldo_good),
    .buck_enable(buck_en), .buck_forced_pwm(pwm), .buck_voltage_select(bvsel),
    .buck_range_select(brange), .buck_soft_start(ss), .ldo_enable(ldo_en),
    .ldo_discharge(ldo_dis), .ldo_voltage_select(lvsel), .ldo7_range_select(l7range));

  rgc_host_model rgc_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_drive_n(host_n));

  // ---------------------------------------------------------------------
  // clock, timeout and reporting
  // ---------------------------------------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // whole run needs about 22k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    rgc_host_model_inst.write_reg(rgc_pkg::DEVICE_ADDR, ptr, data, nack);
    check("write ack", 8'(nack), 8'h00);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] ptr, input logic [7:0] exp);
    rgc_host_model_inst.read_reg(ptr, rd);
    check(name, rd, exp);
  endtask

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req = 3'b000;
    buck_good = 1'b1;
    ldo_good = 8'hA5;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("sda out", 8'(sda_out), 8'h00);
    rd_chk("buck select", 8'h14, 8'h60);
    rd_chk("buck control", 8'h17, 8'h03);
    // each request pin alone turns the converter on
    for (int i = 0; i < 3; i++) begin
      req = 3'(1 << i);
      repeat (3) @(negedge clk);
      check("enable", 8'(buck_en), 8'h01);
      check("ramp", 8'(ss), 8'h01);
      req = 3'b000;
      repeat (3) @(negedge clk);
      check("disable", 8'(buck_en), 8'h00);
    end
    req = 3'b010;
    repeat (SS + 10) @(negedge clk);
    check("ramp end", 8'(ss), 8'h00);
    wr(8'h17, 8'h00);
    check("bit off", 8'(buck_en), 8'h00);
    rd_chk("buck control", 8'h17, 8'h02);
    wr(8'h17, 8'hFF);
    check("bit on", 8'(buck_en), 8'h01);
    buck_good = 1'b0;
    rd_chk("buck good", 8'h17, 8'h01);
    buck_good = 1'b1;
    wr(8'h14, 8'hFF);
    check("buck select", 8'(bvsel), 8'h3F);
    check("buck range", 8'(brange), 8'h01);
    rd_chk("buck select", 8'h14, 8'h7F);
    wr(8'h14, 8'h05);
    check("buck range", 8'(brange), 8'h00);
    wr(8'h15, 8'hFF);
    check("pwm", 8'(pwm), 8'h01);
    rd_chk("mode", 8'h15, 8'h01);
    wr(8'h15, 8'h00);
    check("pwm", 8'(pwm), 8'h00);
    wr(8'h07, 8'hFF);
    check("ldo7 select", 8'(lvsel[6]), 8'h3F);
    check("ldo7 range", 8'(l7range), 8'h01);
    rd_chk("ldo7 select", 8'h07, 8'h7F);
    // every regulator: all ones, then discharge alone
    for (int i = 0; i < 8; i++) begin
      a = rgc_pkg::LDO_CONTROL_ADDR[i];
      e = (i == 6) ? 8'hA0 : 8'hBF;
      wr(a, 8'hFF);
      check("ldo enable", 8'(ldo_en[i]), 8'h01);
      check("ldo discharge", 8'(ldo_dis[i]), 8'h00);
      if (i != 6) check("ldo select", 8'(lvsel[i]), 8'h1F);
      rd_chk("ldo control", a, e | {1'b0, ldo_good[i], 6'h00});
      // flip the good levels so each flag is read both ways
      ldo_good = ~ldo_good;
      wr(a, 8'h80);
      check("ldo enable", 8'(ldo_en[i]), 8'h00);
      check("ldo discharge", 8'(ldo_dis[i]), 8'h01);
      rd_chk("ldo control", a, 8'h80 | {1'b0, ldo_good[i], 6'h00});
    end
    check("ldo7 select", 8'(lvsel[6]), 8'h3F);
    wr(8'h16, 8'hFF);
    rd_chk("reserved", 8'h16, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    rgc_host_model_inst.write_reg(rgc_pkg::DEVICE_ADDR ^ 7'h01, 8'h15, 8'h01, nack);
    check("foreign nack", 8'(nack), 8'h01);
    check("pwm", 8'(pwm), 8'h00);
    // mid-run reset with a request still high: settings go back to defaults
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset select", 8'(bvsel), 8'h20);
    check("reset range", 8'(brange), 8'h01);
    check("reset ldo7", 8'(lvsel[6]), 8'h00);
    check("reset discharge", ldo_dis, 8'h00);
    check("reset enable", 8'(buck_en), 8'h01);
    end_of_test();
  end
endmodule

`default_nettype wire

// File: rgc_regulator_control_chk.sv
// assertion checker for the regulator control register bank
`default_nettype none

module rgc_regulator_control_chk #(
  parameter int SOFTSTART_CYCLES = rgc_pkg::SOFTSTART_CYCLES
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            scl,
  input wire logic            sda_drive_n,
  input wire logic            handsfree_power_request,
  input wire logic            power_on_request,
  input wire logic            power_hold_request,
  input wire logic            buck_enable,
  input wire logic            buck_forced_pwm,
  input wire logic [5:0]      buck_voltage_select,
  input wire logic            buck_range_select,
  input wire logic            buck_soft_start,
  input wire logic [7:0]      ldo_enable,
  input wire logic [7:0]      ldo_discharge,
  input wire logic [7:0][5:0] ldo_voltage_select,
  input wire logic            ldo7_range_select
);
  logic       any_req;
  logic [7:0] wide_top;
  int         ss_run;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // any request pin high
  assign any_req = handsfree_power_request | power_on_request | power_hold_request;

  // top select bit of the five-bit regulators must stay clear
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wide_top[i] = ldo_voltage_select[i][5] & (i != rgc_pkg::LDO7_INDEX);
    end
  end

  // length of the running soft-start window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ss_run <= 0;
    end else begin
      ss_run <= buck_soft_start ? ss_run + 1 : 0;
    end
  end

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_buck_off_idle: assert property (!any_req |=> !buck_enable)
    else $error("converter on with no request");
  a_discharge_when_off: assert property ((ldo_discharge & ldo_enable) == 8'h00)
    else $error("discharge active on enabled regulator");
  a_narrow_select: assert property (wide_top == 8'h00)
    else $error("five-bit select has bit 5 set");
  a_ramp_start: assert property ($rose(buck_enable) |-> ##[0:2] buck_soft_start)
    else $error("no soft start after enable");
  a_ramp_length: assert property (ss_run <= SOFTSTART_CYCLES + 2)
    else $error("soft start too long");
  a_ramp_abort: assert property ($fell(buck_enable) |-> ##[0:2] !buck_soft_start)
    else $error("soft start outlives enable");
  // settings only move after a byte, while the serial clock is low
  a_config_on_write: assert property ($changed({buck_forced_pwm, buck_voltage_select,
      buck_range_select, ldo_enable, ldo_voltage_select, ldo7_range_select})
      |-> !scl && !$past(scl))
    else $error("setting changed outside a write");
  a_sda_clock_low: assert property ($changed(sda_drive_n) |-> !scl)
    else $error("data line moved with clock high");

  cover property ($rose(buck_enable));
  cover property ($rose(buck_forced_pwm));
  cover property ($rose(|ldo_discharge));
  cover property ($fell(sda_drive_n));
endmodule

bind rgc_regulator_control rgc_regulator_control_chk #(
  .SOFTSTART_CYCLES(SOFTSTART_CYCLES)
) rgc_regulator_control_chk_inst (
  .clk(clk), .rst(rst), .scl(scl), .sda_drive_n(sda_drive_n),
  .handsfree_power_request(handsfree_power_request), .power_on_request(power_on_request),
  .power_hold_request(power_hold_request), .buck_enable(buck_enable),
  .buck_forced_pwm(buck_forced_pwm), .buck_voltage_select(buck_voltage_select),
  .buck_range_select(buck_range_select), .buck_soft_start(buck_soft_start),
  .ldo_enable(ldo_enable), .ldo_discharge(ldo_discharge),
  .ldo_voltage_select(ldo_voltage_select), .ldo7_range_select(ldo7_range_select)
);

`default_nettype wire

// File: rgc_serial_slave.sv
// two-wire serial slave that turns bus transfers into register accesses
`default_nettype none

module rgc_serial_slave (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   scl,
  input  wire logic   sda_in,
  output logic        sda_drive_n,
  rgc_reg_if.master   regs
);

  typedef enum logic [3:0] {
    RGC_IDLE, RGC_ADDR, RGC_ADDR_ACK, RGC_PTR, RGC_PTR_ACK,
    RGC_WDATA, RGC_WDATA_ACK, RGC_RDATA, RGC_RACK
  } rgc_state_type;

  rgc_state_type state;
  logic          scl_q;
  logic          sda_q;
  logic [7:0]    shift;
  logic [3:0]    bit_cnt;
  logic [7:0]    ptr;
  logic          master_ack;
  logic          write_q;

  // -------------------------------------------------------------------------
  // bus events
  // -------------------------------------------------------------------------
  // pins are synchronous already, one sample is enough for edges
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl & scl_q & ~sda_q & sda_in;

  // previous pin samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // -------------------------------------------------------------------------
  // transfer sequencer
  // -------------------------------------------------------------------------
  // start wins over everything, so a repeated start keeps the pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= RGC_IDLE;
      shift       <= 8'h00;
      bit_cnt     <= 4'h0;
      ptr         <= 8'h00;
      master_ack  <= 1'b0;
      sda_drive_n <= 1'b1;
      write_q     <= 1'b0;
    end else begin
      write_q <= 1'b0;
      if (bus_start) begin
        state       <= RGC_ADDR;
        bit_cnt     <= 4'h0;
        sda_drive_n <= 1'b1;
      end else if (bus_stop) begin
        state       <= RGC_IDLE;
        sda_drive_n <= 1'b1;
      end else begin
        unique case (state)
          RGC_IDLE: begin
          end
          RGC_ADDR, RGC_PTR, RGC_WDATA: begin
            if (scl_rise && bit_cnt < 4'h8) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              sda_drive_n <= 1'b0; // acknowledge
              if (state == RGC_ADDR) begin
                if (shift[7:1] == rgc_pkg::DEVICE_ADDR) begin
                  state <= RGC_ADDR_ACK;
                  master_ack <= shift[0]; // remembers read direction
                end else begin
                  state       <= RGC_IDLE;
                  sda_drive_n <= 1'b1; // not ours, stay silent
                end
              end else if (state == RGC_PTR) begin
                ptr   <= shift;
                state <= RGC_PTR_ACK;
              end else begin
                write_q <= 1'b1;
                state   <= RGC_WDATA_ACK;
              end
            end
          end
          RGC_ADDR_ACK, RGC_PTR_ACK, RGC_WDATA_ACK: begin
            if (scl_fall) begin
              bit_cnt     <= 4'h0;
              sda_drive_n <= 1'b1;
              if (state == RGC_WDATA_ACK) begin
                ptr   <= ptr + 8'h01; // auto-increment between data bytes
                state <= RGC_WDATA;
              end else if (state == RGC_PTR_ACK) begin
                state <= RGC_WDATA;
              end else if (master_ack) begin
                shift       <= {regs.rdata[6:0], 1'b0};
                sda_drive_n <= regs.rdata[7];
                bit_cnt     <= 4'h1;
                state       <= RGC_RDATA;
              end else begin
                state <= RGC_PTR;
              end
            end
          end
          RGC_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_drive_n <= 1'b1;
                state       <= RGC_RACK;
              end else begin
                sda_drive_n <= shift[7];
                shift       <= {shift[6:0], 1'b0};
                bit_cnt     <= bit_cnt + 4'h1;
              end
            end
          end
          RGC_RACK: begin
            if (scl_rise) begin
              master_ack <= ~sda_in;
              if (!sda_in) begin
                ptr <= ptr + 8'h01;
              end
            end else if (scl_fall) begin
              if (master_ack) begin
                shift       <= {regs.rdata[6:0], 1'b0};
                sda_drive_n <= regs.rdata[7];
                bit_cnt     <= 4'h1;
                state       <= RGC_RDATA;
              end else begin
                state <= RGC_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  assign regs.write = write_q;
  assign regs.addr  = ptr;
  assign regs.wdata = shift;

endmodule

`default_nettype wire
